// ==== common/ppg_pkg.sv ====
// What this block does
// (RULE_01) Period length comes from the software-written 8-bit period limit register.
// (RULE_02) Counter equal to limit clears to zero on the next increment.
// (RULE_03) Rollover sets the output pin unless duty is zero.
// (RULE_04) Rollover copies the master duty value into the slave duty register.
// (RULE_05) Postscaler divides only match events, never the PWM frequency.
// (RULE_06) Duty is 10 bits: master register high eight, control bits 5:4 low two.
// (RULE_07) New duty takes effect only after the next period match.
// (RULE_08) In PWM mode the slave duty register is read-only.
// (RULE_09) Duty is double-buffered in slave register plus hidden 2-bit latch.
// (RULE_10) Output clears when buffered duty equals the 10-bit extended timebase.
// (RULE_11) Duty beyond the period never clears the output.
// (RULE_12) Prescaler divides by 1, 4 or 16.
// (RULE_13) Software sets limit, duty, pin direction, timebase, then PWM mode.
// (RULE_14) Reset loads limit with ones; counter and timebase control with zero.
// (RULE_15) Mode 0000 disables and resets the channel; 11xx selects PWM.
// (RULE_16) Clearing the control register forces the output latch low.
// (RULE_17) Both PWM channels share one period timebase.
// (RULE_18) Divide-by-1 extends with quarter phase, divide-by-4 with low prescaler bits, divide-by-16 with upper ones.
// (RULE_19) Timebase off holds counter and pin, and stops duty transfer.
package ppg_pkg;

  localparam logic [7:0] ADDR_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] ADDR_COUNT = 8'h11;
  localparam logic [7:0] ADDR_TB_CTRL = 8'h12;
  localparam logic [7:0] ADDR_MASTER_A = 8'h15;
  localparam logic [7:0] ADDR_SLAVE_A = 8'h16;
  localparam logic [7:0] ADDR_MODE_A = 8'h17;
  localparam logic [7:0] ADDR_MASTER_B = 8'h1b;
  localparam logic [7:0] ADDR_SLAVE_B = 8'h1c;
  localparam logic [7:0] ADDR_MODE_B = 8'h1d;
  localparam logic [7:0] ADDR_DIRECTION = 8'h87;
  localparam logic [7:0] ADDR_ENABLE_ONE = 8'h8c;
  localparam logic [7:0] ADDR_ENABLE_TWO = 8'h8d;
  localparam logic [7:0] ADDR_LIMIT = 8'h92;

  localparam logic [7:0] LIMIT_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] TB_CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam int TB_RUN_BIT = 2;
  localparam int POST_LSB = 3;
  localparam int DUTY_LOW_LSB = 4;
  localparam int MATCH_FLAG_BIT = 1;
  localparam int PIN_BIT_A = 2;
  localparam int PIN_BIT_B = 1;
  localparam logic [7:0] TB_CTRL_MASK = 8'h7f;
  localparam logic [7:0] MODE_MASK = 8'h3f;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'h01;

  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;

  // One instruction cycle is four system clocks.
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppg_bus_t;

  typedef enum logic [1:0] {
    PPG_OFF = 2'b01,
    PPG_PWM = 2'b10
  } ppg_chan_state_t;

endpackage : ppg_pkg

// ==== verilog/ppg_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppg_top
  import ppg_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Modulated outputs and direction.
  output logic [1:0] PWM_OUT,
  output logic [1:0] PWM_OE_N,
  // Timebase match event after postscaler.
  output logic MATCH_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  ppg_bus_t bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [7:0] period_limit;
  logic [7:0] pwm_timebase_count;
  logic [7:0] timebase_control;
  logic [7:0] port_c_direction;
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic [7:0] enable_one;
  logic [7:0] enable_two;
  logic [1:0] quarter;
  logic [3:0] prescale_cnt;
  logic [3:0] post_cnt;
  logic [7:0] duty_master [2];
  logic [7:0] duty_slave [2];
  logic [7:0] mode_control [2];
  logic [1:0] duty_low_latch [2];
  logic [1:0] pwm_latch;

  wire timebase_run = timebase_control[TB_RUN_BIT];
  wire [1:0] prescale_sel = timebase_control[1:0];
  wire [3:0] post_sel = timebase_control[6:3];
  wire wr_count = bus.wr && bus.addr == ADDR_COUNT;
  wire wr_tb = bus.wr && bus.addr == ADDR_TB_CTRL;
  wire wr_limit = bus.wr && bus.addr == ADDR_LIMIT;
  wire wr_dir = bus.wr && bus.addr == ADDR_DIRECTION;
  wire wr_flags_one = bus.wr && bus.addr == ADDR_FLAGS_ONE;
  wire wr_flags_two = bus.wr && bus.addr == ADDR_FLAGS_TWO;
  wire wr_en_one = bus.wr && bus.addr == ADDR_ENABLE_ONE;
  wire wr_en_two = bus.wr && bus.addr == ADDR_ENABLE_TWO;

  ////////////////////////////////////////////////////////////////////////////
  // Increment tick: one per instruction cycle scaled by the prescaler.
  wire quarter_end = quarter == QUARTER_LAST;
  wire [3:0] prescale_last = (prescale_sel == PRESCALE_DIV1) ? 4'h0 :
                             (prescale_sel == PRESCALE_DIV4) ? 4'h3 : 4'hf; // RULE_12
  wire tick = timebase_run && quarter_end && prescale_cnt == prescale_last; // RULE_19
  wire at_limit = pwm_timebase_count == period_limit; // RULE_01
  wire rollover = tick && at_limit; // RULE_02
  wire [3:0] prescale_cnt_inc = prescale_cnt + 4'h1;
  wire [1:0] ext_bits = (prescale_sel == PRESCALE_DIV1) ? quarter :
                        prescale_cnt[3:2]; // RULE_18
  wire [1:0] ext_div4 = prescale_cnt[1:0];
  wire [1:0] ext_sel = (prescale_sel == PRESCALE_DIV4) ? ext_div4 : ext_bits;
  wire [9:0] timebase10 = {pwm_timebase_count, ext_sel}; // RULE_10
  // The output latch is registered, so the clear is taken on the step that leaves the value
  // just below the duty; the pin then falls as the timebase enters the duty value.
  wire [9:0] timebase10_inc = timebase10 + 10'h001;
  wire step_div16 = prescale_cnt[1:0] == 2'h3;
  wire tb_step = timebase_run && (prescale_sel == PRESCALE_DIV1 ||
                 (quarter_end && (prescale_sel == PRESCALE_DIV4 || step_div16))); // RULE_18
  wire post_hit = post_cnt == post_sel;
  wire [3:0] post_cnt_inc = post_cnt + 4'h1;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      quarter <= 2'h0;
    end else if (timebase_run) begin
      quarter <= quarter + 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || wr_tb || wr_count) begin
      prescale_cnt <= 4'h0;
    end else if (timebase_run && quarter_end) begin
      prescale_cnt <= (prescale_cnt == prescale_last) ? 4'h0 : prescale_cnt_inc;
    end
  end

  // The shared counter serves both channels, so they run at one frequency.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pwm_timebase_count <= COUNT_RESET; // RULE_14
    end else if (wr_count) begin
      pwm_timebase_count <= bus.wdata;
    end else if (rollover) begin
      pwm_timebase_count <= COUNT_RESET; // RULE_02 RULE_17
    end else if (tick) begin
      pwm_timebase_count <= pwm_timebase_count + 8'h01;
    end
  end

  // Postscaler only counts matches; it never touches the period.
  always_ff @(posedge CLK) begin
    if (SYS_RST || wr_tb) begin
      post_cnt <= 4'h0;
    end else if (rollover) begin
      post_cnt <= post_hit ? 4'h0 : post_cnt_inc; // RULE_05
    end
  end

  // Hardware set wins over a software write in the same cycle.
  wire [7:0] flags_one_w = wr_flags_one ? bus.wdata : flags_one;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_one <= ZERO_BYTE;
    end else begin
      flags_one <= flags_one_w | {6'h00, rollover && post_hit, 1'b0}; // RULE_05
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      period_limit <= LIMIT_RESET; // RULE_14
      timebase_control <= TB_CTRL_RESET; // RULE_14
      port_c_direction <= DIRECTION_RESET;
      flags_two <= ZERO_BYTE;
      enable_one <= ZERO_BYTE;
      enable_two <= ZERO_BYTE;
    end else begin
      if (wr_limit) period_limit <= bus.wdata; // RULE_01
      if (wr_tb) timebase_control <= bus.wdata & TB_CTRL_MASK;
      if (wr_dir) port_c_direction <= bus.wdata;
      if (wr_flags_two) flags_two <= bus.wdata & FLAGS_TWO_MASK;
      if (wr_en_one) enable_one <= bus.wdata;
      if (wr_en_two) enable_two <= bus.wdata & FLAGS_TWO_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel duty buffering and output latch.
  localparam logic [7:0] MASTER_ADDR [2] = '{ADDR_MASTER_A, ADDR_MASTER_B};
  localparam logic [7:0] SLAVE_ADDR [2] = '{ADDR_SLAVE_A, ADDR_SLAVE_B};
  localparam logic [7:0] MODE_ADDR [2] = '{ADDR_MODE_A, ADDR_MODE_B};
  wire [7:0] pin_dir_bits = port_c_direction;
  logic [1:0] chan_pwm;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      ppg_chan_state_t state;
      wire wr_master = bus.wr && bus.addr == MASTER_ADDR[ch];
      wire wr_slave = bus.wr && bus.addr == SLAVE_ADDR[ch];
      wire wr_mode = bus.wr && bus.addr == MODE_ADDR[ch];
      wire [3:0] mode = mode_control[ch][3:0];
      wire mode_off = mode == 4'h0; // RULE_15
      assign state = (mode[3:2] == 2'b11) ? PPG_PWM : PPG_OFF; // RULE_15
      assign chan_pwm[ch] = state == PPG_PWM;
      wire [9:0] duty_sw = {duty_master[ch],
                            mode_control[ch][DUTY_LOW_LSB+1:DUTY_LOW_LSB]}; // RULE_06
      wire [9:0] duty_buf = {duty_slave[ch], duty_low_latch[ch]}; // RULE_09
      wire clear_hit = tb_step && duty_buf == timebase10_inc; // RULE_10 RULE_11

      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          mode_control[ch] <= MODE_RESET;
          duty_master[ch] <= ZERO_BYTE;
        end else begin
          if (wr_mode) mode_control[ch] <= bus.wdata & MODE_MASK;
          if (wr_master) duty_master[ch] <= bus.wdata; // RULE_07
        end
      end

      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          duty_slave[ch] <= ZERO_BYTE;
          duty_low_latch[ch] <= 2'h0;
        end else if (chan_pwm[ch] && rollover) begin
          duty_slave[ch] <= duty_sw[9:2]; // RULE_04 RULE_07
          duty_low_latch[ch] <= duty_sw[1:0]; // RULE_09
        end else if (wr_slave && !chan_pwm[ch]) begin
          duty_slave[ch] <= bus.wdata; // RULE_08
        end
      end

      always_ff @(posedge CLK) begin
        if (SYS_RST || mode_off || !chan_pwm[ch]) begin
          pwm_latch[ch] <= 1'b0; // RULE_15 RULE_16
        end else if (rollover) begin
          pwm_latch[ch] <= duty_sw != 10'h000; // RULE_03
        end else if (clear_hit) begin
          pwm_latch[ch] <= 1'b0; // RULE_10
        end
      end
    end
  endgenerate

  // Step order is up to software; the pin is driven only when enabled.
  wire [1:0] oe_n_next = {pin_dir_bits[PIN_BIT_B], pin_dir_bits[PIN_BIT_A]}; // RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped addresses read zero.
  logic [7:0] next_rdata;
  always_comb begin
    case (bus.addr)
      ADDR_FLAGS_ONE: next_rdata = flags_one;
      ADDR_FLAGS_TWO: next_rdata = flags_two;
      ADDR_COUNT: next_rdata = pwm_timebase_count;
      ADDR_TB_CTRL: next_rdata = timebase_control;
      ADDR_MASTER_A: next_rdata = duty_master[0];
      ADDR_SLAVE_A: next_rdata = duty_slave[0];
      ADDR_MODE_A: next_rdata = mode_control[0];
      ADDR_MASTER_B: next_rdata = duty_master[1];
      ADDR_SLAVE_B: next_rdata = duty_slave[1];
      ADDR_MODE_B: next_rdata = mode_control[1];
      ADDR_DIRECTION: next_rdata = port_c_direction;
      ADDR_ENABLE_ONE: next_rdata = enable_one;
      ADDR_ENABLE_TWO: next_rdata = enable_two;
      ADDR_LIMIT: next_rdata = period_limit;
      default: next_rdata = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= ZERO_BYTE;
      PWM_OUT <= 2'b00;
      PWM_OE_N <= 2'b11;
      MATCH_FLAG <= 1'b0;
    end else begin
      RDATA <= bus.rd ? next_rdata : ZERO_BYTE;
      PWM_OUT <= pwm_latch;
      PWM_OE_N <= oe_n_next;
      MATCH_FLAG <= flags_one[MATCH_FLAG_BIT];
    end
  end

endmodule : ppg_top
`default_nettype wire

// ==== testbench/ppg_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppg_props
  import ppg_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Pins and flag.
  input wire logic [1:0] PWM_OUT,
  input wire logic [1:0] PWM_OE_N,
  input wire logic MATCH_FLAG
);
  logic [7:0] lim, tbc, mode, mst;
  logic [2:0] hold;
  wire logic wr_ctl = WR && (ADDR == ADDR_TB_CTRL || ADDR == ADDR_MODE_A ||
    ADDR == ADDR_MODE_B || ADDR == ADDR_COUNT || ADDR == ADDR_FLAGS_ONE);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lim <= LIMIT_RESET;
      tbc <= TB_CTRL_RESET;
      mode <= MODE_RESET;
      mst <= ZERO_BYTE;
    end else if (WR) begin
      if (ADDR == ADDR_LIMIT) lim <= WDATA;
      if (ADDR == ADDR_TB_CTRL) tbc <= WDATA;
      if (ADDR == ADDR_MODE_A) mode <= WDATA;
      if (ADDR == ADDR_MASTER_A) mst <= WDATA;
    end
  end
  // Cycles spent with the timebase stopped and no control write; saturates.
  always_ff @(posedge CLK) begin
    if (SYS_RST || wr_ctl) hold <= 3'h0;
    else if (!tbc[TB_RUN_BIT] && hold != 3'h7) hold <= hold + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  sequence s_dir_wr;
    WR && ADDR == ADDR_DIRECTION;
  endsequence
  sequence s_mode_a_off;
    WR && ADDR == ADDR_MODE_A && WDATA[3:2] != 2'b11;
  endsequence
  AST_LIMIT_READ: assert property (s_rd(ADDR_LIMIT) |=> RDATA == lim)
    else $error("period limit read mismatch");
  AST_TBCTRL_READ: assert property (s_rd(ADDR_TB_CTRL) |=> RDATA == (tbc & TB_CTRL_MASK))
    else $error("timebase control read mismatch");
  AST_MODE_READ: assert property (s_rd(ADDR_MODE_A) |=> RDATA == (mode & MODE_MASK))
    else $error("mode read mismatch");
  AST_MASTER_READ: assert property (s_rd(ADDR_MASTER_A) |=> RDATA == mst)
    else $error("duty master read mismatch");
  AST_MODE_OFF_A: assert property (s_mode_a_off |-> ##3 !PWM_OUT[0])
    else $error("channel a output high outside pwm mode");
  AST_MODE_ZERO_B: assert property (WR && ADDR == ADDR_MODE_B && WDATA == ZERO_BYTE
    |-> ##3 PWM_OUT[1] == 1'b0) else $error("channel b output not cleared");
  AST_HOLD_OFF: assert property (hold[2] |-> $stable(PWM_OUT) && $stable(MATCH_FLAG))
    else $error("outputs moved while timebase stopped");
  AST_DIR_OE: assert property (s_dir_wr |-> ##2 PWM_OE_N ==
    {$past(WDATA[PIN_BIT_B], 2), $past(WDATA[PIN_BIT_A], 2)}) else $error("enable mismatch");
endmodule : ppg_props
bind ppg_top ppg_props ppg_props_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N), .MATCH_FLAG(MATCH_FLAG)
);
`default_nettype wire

// ==== testbench/ppg_load.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppg_load (
  // Clock and tally clear.
  input wire logic clk,
  input wire logic clr,
  // Device pins.
  input wire logic [1:0] pin,
  input wire logic [1:0] oe_n,
  // High cycles seen per channel.
  output logic [31:0] hi [2]
);
  // An undriven pin is pulled low by the load resistor.
  wire logic [1:0] lvl = pin & ~oe_n;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      hi[i] <= clr ? 32'h0 : hi[i] + 32'(lvl[i]);
    end
  end
endmodule : ppg_load
`default_nettype wire

// ==== testbench/ppg_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppg_top_tb
  import ppg_pkg::*;
;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic clr = 1'b1;
  logic [7:0] RDATA;
  logic [1:0] PWM_OUT, PWM_OE_N;
  logic MATCH_FLAG;
  logic [31:0] hi [2];
  int error_cnt = 0;
  int tests_run = 0;
  always #5 CLK = ~CLK;
  ppg_top ppg_top_i (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N), .MATCH_FLAG(MATCH_FLAG));
  ppg_load ppg_load_i (.clk(CLK), .clr(clr), .pin(PWM_OUT), .oe_n(PWM_OE_N), .hi(hi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : note
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic cmp_reg(input logic [7:0] a, input logic [7:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    note({24'h0, RDATA}, {24'h0, exp});
    @(posedge CLK);
  endtask : cmp_reg
  task automatic cmp_hi(input logic [31:0] got, input int exp);
    note(got, 32'(exp));
  endtask : cmp_hi
  task automatic cmp_flag(input logic exp);
    #1;
    note({31'h0, MATCH_FLAG}, {31'h0, exp});
    @(posedge CLK);
  endtask : cmp_flag
  // High time is the duty in timebase steps; zero never sets, overlong never clears.
  function automatic int hi_exp(input int d, input int lim, input int p);
    if (d == 0) return 0;
    if (d >= 4 * (lim + 1)) return 4 * (lim + 1) * p;
    return d * p;
  endfunction : hi_exp
  task automatic run_case(input int lim, input int da, input int db, input int ps);
    int p;
    int per;
    p = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
    per = (lim + 1) * 4 * p;
    wr(ADDR_MODE_A, ZERO_BYTE);
    wr(ADDR_MODE_B, ZERO_BYTE);
    wr(ADDR_TB_CTRL, TB_CTRL_RESET);
    wr(ADDR_COUNT, COUNT_RESET);
    wr(ADDR_LIMIT, 8'(lim));
    wr(ADDR_MASTER_A, 8'(da >> 2));
    wr(ADDR_MASTER_B, 8'(db >> 2));
    wr(ADDR_DIRECTION, 8'hf9);
    wr(ADDR_TB_CTRL, {1'b0, 4'($urandom), 1'b1, 2'(ps)});
    wr(ADDR_MODE_A, {2'h0, 2'(da), 4'hc});
    wr(ADDR_MODE_B, {2'h0, 2'(db), 4'hc});
    repeat (2 * per) @(posedge CLK);
    clr <= 1'b0;
    repeat (per) @(posedge CLK);
    clr <= 1'b1;
    #1;
    cmp_hi(hi[0], hi_exp(da, lim, p));
    cmp_hi(hi[1], hi_exp(db, lim, p));
    @(posedge CLK);
  endtask : run_case
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] ra [10] = '{ADDR_LIMIT, ADDR_COUNT, ADDR_TB_CTRL, ADDR_MODE_A, ADDR_MODE_B,
      ADDR_DIRECTION, ADDR_MASTER_A, ADDR_SLAVE_A, ADDR_FLAGS_ONE, 8'h40};
    logic [7:0] rv [10] = '{LIMIT_RESET, COUNT_RESET, TB_CTRL_RESET, MODE_RESET, MODE_RESET,
      DIRECTION_RESET, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE};
    int lt [6] = '{3, 3, 2, 1, 0, 0};
    int at [6] = '{6, 0, 5, 3, 0, 0};
    int bt [6] = '{13, 20, 11, 7, 0, 0};
    int pt [6] = '{0, 0, 1, 2, 0, 0};
    void'($urandom(61485));
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    wr(8'h40, 8'h3c);
    for (int i = 0; i < 10; i++) cmp_reg(ra[i], rv[i]);
    for (int i = 4; i < 6; i++) begin
      lt[i] = 1 + $urandom % 6;
      at[i] = $urandom % (4 * lt[i] + 4);
      bt[i] = $urandom % 40;
      pt[i] = $urandom % 3;
    end
    for (int i = 0; i < 6; i++) run_case(lt[i], at[i], bt[i], pt[i]);
    wr(ADDR_TB_CTRL, TB_CTRL_RESET);
    wr(ADDR_COUNT, COUNT_RESET);
    wr(ADDR_LIMIT, 8'h01);
    wr(ADDR_MASTER_A, 8'h5a);
    cmp_reg(ADDR_MASTER_A, 8'h5a);
    cmp_reg(ADDR_SLAVE_A, 8'(at[5] >> 2));
    wr(ADDR_SLAVE_A, 8'ha5);
    cmp_reg(ADDR_SLAVE_A, 8'(at[5] >> 2));
    wr(ADDR_TB_CTRL, 8'h04);
    repeat (20) @(posedge CLK);
    cmp_reg(ADDR_SLAVE_A, 8'h5a);
    // Limit 1 at divide by 1: a rollover every 8 clocks; postscale 2 flags every third one.
    wr(ADDR_TB_CTRL, TB_CTRL_RESET);
    wr(ADDR_COUNT, COUNT_RESET);
    wr(ADDR_FLAGS_ONE, ZERO_BYTE);
    wr(ADDR_TB_CTRL, 8'h14);
    repeat (18) @(posedge CLK);
    cmp_flag(1'b0);
    repeat (6) @(posedge CLK);
    cmp_flag(1'b1);
    test_done();
  end
  initial begin
    repeat (100000) @(posedge CLK);
    error_cnt++;
    test_done();
  end
endmodule : ppg_top_tb
`default_nettype wire
